//--- mtc_pkg.sv
package mtc_pkg;
    // ==========================================================
    // register addresses on the special function bus
    localparam logic [7:0] ADDR_RUN_FLAG   = 8'h88;
    localparam logic [7:0] ADDR_MODE_SEL   = 8'h89;
    localparam logic [7:0] ADDR_T0_LOW     = 8'h8A;
    localparam logic [7:0] ADDR_T1_LOW     = 8'h8B;
    localparam logic [7:0] ADDR_T0_HIGH    = 8'h8C;
    localparam logic [7:0] ADDR_T1_HIGH    = 8'h8D;
    localparam logic [7:0] ADDR_T2_CTRL    = 8'hC8;
    localparam logic [7:0] ADDR_RELOAD_LOW = 8'hCA;
    localparam logic [7:0] ADDR_RELOAD_HI  = 8'hCB;
    localparam logic [7:0] ADDR_T2_LOW     = 8'hCC;
    localparam logic [7:0] ADDR_T2_HIGH    = 8'hCD;
    localparam logic [7:0] RESET_BYTE      = 8'h00;
    // ==========================================================
    // run/flag control bit positions
    localparam int BIT_OVF_ONE   = 7;
    localparam int BIT_RUN_ONE   = 6;
    localparam int BIT_OVF_ZERO  = 5;
    localparam int BIT_RUN_ZERO  = 4;
    localparam int BIT_IRQ_ONE   = 3;
    localparam int BIT_TYPE_ONE  = 2;
    localparam int BIT_IRQ_ZERO  = 1;
    localparam int BIT_TYPE_ZERO = 0;
    // mode select: counter select bits, mode fields
    localparam int BIT_CT_ONE    = 6;
    localparam int BIT_CT_ZERO   = 2;
    localparam int MODE_ONE_LSB  = 4;
    localparam int MODE_ZERO_LSB = 0;
    // third timer control
    localparam int BIT_PRESCALE  = 7;
    localparam int RELOAD_LSB    = 3;
    localparam int INSEL_LSB     = 0;
    // ==========================================================
    // mode encodings
    localparam logic [1:0] MODE_13BIT = 2'h0;
    localparam logic [1:0] MODE_16BIT = 2'h1;
    localparam logic [1:0] MODE_8RELD = 2'h2;
    localparam logic [1:0] MODE_SPLIT = 2'h3;
    localparam logic [1:0] INSEL_STOP  = 2'h0;
    localparam logic [1:0] INSEL_TIMER = 2'h1;
    localparam logic [1:0] INSEL_EVENT = 2'h2;
    localparam logic [1:0] INSEL_GATED = 2'h3;
    localparam logic [1:0] RELOAD_OVF  = 2'h2;
    localparam logic [1:0] RELOAD_TRIG = 2'h3;
    // ==========================================================
    // timing
    localparam int          CLK_PERIOD_NS = 10;
    localparam logic [4:0]  DIV_TWELVE    = 5'h0C;
    localparam logic [4:0]  DIV_TWENTYFOUR = 5'h18;
    localparam logic [4:0]  DIV_ONE       = 5'h01;
    localparam logic [4:0]  DIV_ZERO      = 5'h00;
    localparam logic [4:0]  LOW5_MASK     = 5'h1F;
endpackage : mtc_pkg

//--- mtc_edge_detect.sv
module mtc_edge_detect
    import mtc_pkg::*;
(
    input  wire logic sys_clk,
    input  wire logic rst,
    input  wire logic pin,
    output logic      fall
);
    // ==========================================================
    // sample register
    logic sampled;
    logic prev;

    // two registered samples: one edge recognised in two cycles
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            sampled <= 1'b1;
            prev    <= 1'b1;
            fall    <= 1'b0;
        end else begin
            sampled <= pin;
            prev    <= sampled;
            fall    <= prev & ~sampled;
        end
    end

    property p_fall_cause;
        @(posedge sys_clk) disable iff (rst)
        fall |-> $past(prev) && !$past(sampled);
    endproperty
    a_fall_cause: assert property (p_fall_cause)
        else $error("fall pulse without a one-to-zero sample");
endmodule : mtc_edge_detect

//--- mtc_prescaler.sv
module mtc_prescaler
    import mtc_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       rst,
    input  wire logic [4:0] divide,
    output logic            tick
);
    // ==========================================================
    // free-running divider, one-cycle pulse per period
    logic [4:0] count;
    logic       wrap;

    assign wrap = (count >= divide - DIV_ONE);

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            count <= DIV_ZERO;
            tick  <= 1'b0;
        end else begin
            count <= wrap ? DIV_ZERO : count + DIV_ONE;
            tick  <= wrap;
        end
    end
endmodule : mtc_prescaler

//--- mtc_timers.sv
// Notes on behaviour
// - timer mode counts every twelve clocks
// - counter mode counts count-pin falling edges
// - edge recognition takes two clock cycles
// - sixteen bits held as high/low bytes
// - mode zero: thirteen bits, low five
// - mode one: full sixteen bit counter
// - mode two: eight bit auto reload
// - mode three splits zero, stops one
// - timer one keeps working during split
// - mode field encodes four modes
// - select bit chooses pin or clock
// - third timer timer mode from clock
// - prescale bit picks twelve or twentyfour
// - event mode counts after sampled fall
// - event rate at most half clock
// - gated mode counts only gate high
// - reload mode zero reloads on overflow
// - reload mode one on trigger fall
// - reload field decodes off, zero, one
// - hardware sets both overflow flags
// - clear run bit stops the timer
// - type bits pick edge or level
// - flags clear on service entry
module mtc_timers
    import mtc_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       rst,
    input  wire logic [7:0] sfr_addr,
    input  wire logic       sfr_wr,
    input  wire logic [7:0] sfr_wdata,
    output logic [7:0]      sfr_rdata,
    input  wire logic       count_pin_zero,
    input  wire logic       count_pin_one,
    input  wire logic       count_gate_pin_two,
    input  wire logic       reload_trigger_input,
    input  wire logic       ext_irq_pin_zero_n,
    input  wire logic       ext_irq_pin_one_n,
    input  wire logic       service_ovf_zero,
    input  wire logic       service_ovf_one,
    input  wire logic       service_irq_zero,
    input  wire logic       service_irq_one,
    output logic            overflow_flag_zero,
    output logic            overflow_flag_one,
    output logic            ext_irq_flag_zero,
    output logic            ext_irq_flag_one,
    output logic            timer_one_overflow_pulse
);
    // ==========================================================
    // registers
    logic [7:0] timer_run_and_flag_control_ctl;
    logic [7:0] timer_mode_select;
    logic [7:0] third_timer_control;
    logic [7:0] timer_zero_low_byte;
    logic [7:0] timer_zero_high_byte;
    logic [7:0] timer_one_low_byte;
    logic [7:0] timer_one_high_byte;
    logic [7:0] timer_two_low_byte;
    logic [7:0] timer_two_high_byte;
    logic [7:0] reload_low;
    logic [7:0] reload_high;
    logic       irq_prev_zero;
    logic       irq_prev_one;

    // ==========================================================
    // helpers
    function automatic logic [8:0] inc8(input logic [7:0] v);
        inc8 = {1'b0, v} + 9'h001;
    endfunction : inc8

    // ==========================================================
    // tick sources
    logic tick_twelve;
    logic tick_two;
    logic fall_zero;
    logic fall_one;
    logic fall_two;
    logic fall_trig;
    logic [4:0] t2_div;

    assign t2_div = third_timer_control[BIT_PRESCALE]
                    ? DIV_TWENTYFOUR : DIV_TWELVE;

    mtc_prescaler u_pre_twelve (
        .sys_clk (sys_clk),
        .rst     (rst),
        .divide  (DIV_TWELVE),
        .tick    (tick_twelve)
    );

    mtc_prescaler u_pre_two (
        .sys_clk (sys_clk),
        .rst     (rst),
        .divide  (t2_div),
        .tick    (tick_two)
    );

    mtc_edge_detect u_edge_zero (
        .sys_clk (sys_clk),
        .rst     (rst),
        .pin     (count_pin_zero),
        .fall    (fall_zero)
    );

    mtc_edge_detect u_edge_one (
        .sys_clk (sys_clk),
        .rst     (rst),
        .pin     (count_pin_one),
        .fall    (fall_one)
    );

    mtc_edge_detect u_edge_two (
        .sys_clk (sys_clk),
        .rst     (rst),
        .pin     (count_gate_pin_two),
        .fall    (fall_two)
    );

    mtc_edge_detect u_edge_trig (
        .sys_clk (sys_clk),
        .rst     (rst),
        .pin     (reload_trigger_input),
        .fall    (fall_trig)
    );

    // ==========================================================
    // decode
    logic [1:0] mode_zero;
    logic [1:0] mode_one;
    logic [1:0] t2_insel;
    logic [1:0] t2_reload;
    logic       run_zero;
    logic       run_one;
    logic       step_zero;
    logic       step_one;
    logic       step_zero_hi;
    logic       step_two;
    logic       wr_run;

    assign mode_zero = timer_mode_select[MODE_ZERO_LSB +: 2];
    assign mode_one  = timer_mode_select[MODE_ONE_LSB +: 2];
    assign t2_insel  = third_timer_control[INSEL_LSB +: 2];
    assign t2_reload = third_timer_control[RELOAD_LSB +: 2];
    assign run_zero  = timer_run_and_flag_control_ctl[BIT_RUN_ZERO];
    assign run_one   = timer_run_and_flag_control_ctl[BIT_RUN_ONE];

    // counter select: pin edges when set, clock/12 when clear
    assign step_zero = run_zero & (timer_mode_select[BIT_CT_ZERO]
                       ? fall_zero : tick_twelve);
    // split mode: the high half of timer zero borrows timer one's run bit
    assign step_zero_hi = run_one & tick_twelve;
    // timer one runs on, unaffected by timer zero's split mode
    assign step_one  = run_one & (mode_one != MODE_SPLIT)
                       & (timer_mode_select[BIT_CT_ONE]
                       ? fall_one : tick_twelve);

    always_comb begin
        case (t2_insel)
            INSEL_TIMER: step_two = tick_two;
            INSEL_EVENT: step_two = fall_two;
            INSEL_GATED: step_two = tick_two & count_gate_pin_two;
            default:     step_two = 1'b0;
        endcase
    end

    // ==========================================================
    // next values for timers zero and one
    logic [7:0] next_t0_lo;
    logic [7:0] next_t0_hi;
    logic [7:0] next_t1_lo;
    logic [7:0] next_t1_hi;
    logic       ovf_zero;
    logic       ovf_one;

    function automatic logic [16:0] step16(
        input logic [1:0] mode,
        input logic [7:0] hi,
        input logic [7:0] lo
    );
        logic [8:0] l;
        logic [8:0] h;
        logic [4:0] l5;
        l = inc8(lo);
        h = inc8(hi);
        l5 = lo[4:0] & LOW5_MASK;
        step16 = {1'b0, hi, lo};
        case (mode)
            MODE_13BIT: begin
                if (l5 == LOW5_MASK)
                    step16 = {h, lo[7:5], 5'h00};
                else
                    step16 = {1'b0, hi, lo[7:5], l5 + 5'h01};
            end
            MODE_16BIT: begin
                if (l[8])
                    step16 = {h, 8'h00};
                else
                    step16 = {1'b0, hi, l[7:0]};
            end
            MODE_8RELD: step16 = {l[8], hi, l[8] ? hi : l[7:0]};
            MODE_SPLIT: step16 = {l[8], hi, l[7:0]};
            default:    step16 = {1'b0, hi, lo};
        endcase
    endfunction : step16

    logic [16:0] r_zero;
    logic [16:0] r_one;
    logic [8:0]  split_hi;

    assign r_zero   = step16(mode_zero, timer_zero_high_byte,
                             timer_zero_low_byte);
    assign r_one    = step16(mode_one, timer_one_high_byte,
                             timer_one_low_byte);
    assign split_hi = inc8(timer_zero_high_byte);

    logic split;
    assign split = (mode_zero == MODE_SPLIT);

    assign next_t0_lo = step_zero ? r_zero[7:0] : timer_zero_low_byte;
    assign next_t0_hi = split ? (step_zero_hi ? split_hi[7:0]
                        : timer_zero_high_byte)
                        : (step_zero ? r_zero[15:8] : timer_zero_high_byte);
    assign next_t1_lo = step_one ? r_one[7:0] : timer_one_low_byte;
    assign next_t1_hi = step_one ? r_one[15:8] : timer_one_high_byte;
    assign ovf_zero   = step_zero & r_zero[16];
    // in split mode timer zero's high half owns overflow flag one
    assign ovf_one    = split ? (step_zero_hi & split_hi[8])
                        : (step_one & r_one[16]);
    assign timer_one_overflow_pulse = step_one & r_one[16];

    // ==========================================================
    // timer two
    logic [16:0] t2_inc;
    logic        t2_reload_now;
    assign t2_inc = {1'b0, timer_two_high_byte, timer_two_low_byte}
                    + 17'h00001;
    assign t2_reload_now = ((t2_reload == RELOAD_OVF) & step_two
                            & t2_inc[16])
                         | ((t2_reload == RELOAD_TRIG) & fall_trig);

    // ==========================================================
    // register bus decode
    logic wr_mode;
    logic wr_t2c;
    logic wr_t0l;
    logic wr_t0h;
    logic wr_t1l;
    logic wr_t1h;
    logic wr_t2l;
    logic wr_t2h;
    logic wr_rl;
    logic wr_rh;
    assign wr_run  = sfr_wr & (sfr_addr == ADDR_RUN_FLAG);
    assign wr_mode = sfr_wr & (sfr_addr == ADDR_MODE_SEL);
    assign wr_t2c  = sfr_wr & (sfr_addr == ADDR_T2_CTRL);
    assign wr_t0l  = sfr_wr & (sfr_addr == ADDR_T0_LOW);
    assign wr_t0h  = sfr_wr & (sfr_addr == ADDR_T0_HIGH);
    assign wr_t1l  = sfr_wr & (sfr_addr == ADDR_T1_LOW);
    assign wr_t1h  = sfr_wr & (sfr_addr == ADDR_T1_HIGH);
    assign wr_t2l  = sfr_wr & (sfr_addr == ADDR_T2_LOW);
    assign wr_t2h  = sfr_wr & (sfr_addr == ADDR_T2_HIGH);
    assign wr_rl   = sfr_wr & (sfr_addr == ADDR_RELOAD_LOW);
    assign wr_rh   = sfr_wr & (sfr_addr == ADDR_RELOAD_HI);

    // ==========================================================
    // external interrupt flag sources
    logic irq_set_zero;
    logic irq_set_one;
    assign irq_set_zero = timer_run_and_flag_control_ctl[BIT_TYPE_ZERO]
                          ? (irq_prev_zero & ~ext_irq_pin_zero_n)
                          : ~ext_irq_pin_zero_n;
    assign irq_set_one  = timer_run_and_flag_control_ctl[BIT_TYPE_ONE]
                          ? (irq_prev_one & ~ext_irq_pin_one_n)
                          : ~ext_irq_pin_one_n;

    // flag update: hardware set wins over software write or service clear
    function automatic logic flag_next(
        input logic cur,
        input logic set,
        input logic svc,
        input logic wr,
        input logic wval
    );
        flag_next = set ? 1'b1 : (svc ? 1'b0 : (wr ? wval : cur));
    endfunction : flag_next

    logic [7:0] next_ctl;
    always_comb begin
        next_ctl = wr_run ? sfr_wdata : timer_run_and_flag_control_ctl;
        next_ctl[BIT_OVF_ZERO] = flag_next(
            timer_run_and_flag_control_ctl[BIT_OVF_ZERO], ovf_zero,
            service_ovf_zero, wr_run, sfr_wdata[BIT_OVF_ZERO]);
        next_ctl[BIT_OVF_ONE] = flag_next(
            timer_run_and_flag_control_ctl[BIT_OVF_ONE], ovf_one,
            service_ovf_one, wr_run, sfr_wdata[BIT_OVF_ONE]);
        next_ctl[BIT_IRQ_ZERO] = flag_next(
            timer_run_and_flag_control_ctl[BIT_IRQ_ZERO], irq_set_zero,
            service_irq_zero, wr_run, sfr_wdata[BIT_IRQ_ZERO]);
        next_ctl[BIT_IRQ_ONE] = flag_next(
            timer_run_and_flag_control_ctl[BIT_IRQ_ONE], irq_set_one,
            service_irq_one, wr_run, sfr_wdata[BIT_IRQ_ONE]);
    end

    // ==========================================================
    // state
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            timer_run_and_flag_control_ctl <= RESET_BYTE;
            timer_mode_select    <= RESET_BYTE;
            third_timer_control  <= RESET_BYTE;
            reload_low           <= RESET_BYTE;
            reload_high          <= RESET_BYTE;
            irq_prev_zero        <= 1'b1;
            irq_prev_one         <= 1'b1;
        end else begin
            timer_run_and_flag_control_ctl <= next_ctl;
            if (wr_mode) timer_mode_select <= sfr_wdata;
            if (wr_t2c) third_timer_control <= sfr_wdata;
            if (wr_rl) reload_low <= sfr_wdata;
            if (wr_rh) reload_high <= sfr_wdata;
            irq_prev_zero <= ext_irq_pin_zero_n;
            irq_prev_one  <= ext_irq_pin_one_n;
        end
    end

    // software writes take precedence over a count in the same cycle
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            timer_zero_low_byte  <= RESET_BYTE;
            timer_zero_high_byte <= RESET_BYTE;
            timer_one_low_byte   <= RESET_BYTE;
            timer_one_high_byte  <= RESET_BYTE;
        end else begin
            timer_zero_low_byte  <= wr_t0l ? sfr_wdata : next_t0_lo;
            timer_zero_high_byte <= wr_t0h ? sfr_wdata : next_t0_hi;
            timer_one_low_byte   <= wr_t1l ? sfr_wdata : next_t1_lo;
            timer_one_high_byte  <= wr_t1h ? sfr_wdata : next_t1_hi;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            timer_two_low_byte  <= RESET_BYTE;
            timer_two_high_byte <= RESET_BYTE;
        end else if (wr_t2l | wr_t2h) begin
            if (wr_t2l) timer_two_low_byte  <= sfr_wdata;
            if (wr_t2h) timer_two_high_byte <= sfr_wdata;
        end else if (t2_reload_now) begin
            timer_two_low_byte  <= reload_low;
            timer_two_high_byte <= reload_high;
        end else if (step_two) begin
            timer_two_low_byte  <= t2_inc[7:0];
            timer_two_high_byte <= t2_inc[15:8];
        end
    end

    // ==========================================================
    // read mux, registered; unmapped reads give zero
    logic [7:0] rd_mux;
    always_comb begin
        case (sfr_addr)
            ADDR_RUN_FLAG:   rd_mux = timer_run_and_flag_control_ctl;
            ADDR_MODE_SEL:   rd_mux = timer_mode_select;
            ADDR_T2_CTRL:    rd_mux = third_timer_control;
            ADDR_T0_LOW:     rd_mux = timer_zero_low_byte;
            ADDR_T0_HIGH:    rd_mux = timer_zero_high_byte;
            ADDR_T1_LOW:     rd_mux = timer_one_low_byte;
            ADDR_T1_HIGH:    rd_mux = timer_one_high_byte;
            ADDR_T2_LOW:     rd_mux = timer_two_low_byte;
            ADDR_T2_HIGH:    rd_mux = timer_two_high_byte;
            ADDR_RELOAD_LOW: rd_mux = reload_low;
            ADDR_RELOAD_HI:  rd_mux = reload_high;
            default:         rd_mux = RESET_BYTE;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (rst) sfr_rdata <= RESET_BYTE;
        else     sfr_rdata <= rd_mux;
    end

    assign overflow_flag_zero = timer_run_and_flag_control_ctl[BIT_OVF_ZERO];
    assign overflow_flag_one  = timer_run_and_flag_control_ctl[BIT_OVF_ONE];
    assign ext_irq_flag_zero  = timer_run_and_flag_control_ctl[BIT_IRQ_ZERO];
    assign ext_irq_flag_one   = timer_run_and_flag_control_ctl[BIT_IRQ_ONE];

    // ==========================================================
    // checks
    property p_stop_hold;
        @(posedge sys_clk) disable iff (rst)
        (!run_one && !wr_t1l && !wr_t1h) |=>
            $stable(timer_one_low_byte) && $stable(timer_one_high_byte);
    endproperty
    a_stop_hold: assert property (p_stop_hold)
        else $error("stopped timer one changed");

    property p_ovf_sets;
        @(posedge sys_clk) disable iff (rst)
        ovf_zero |=> overflow_flag_zero;
    endproperty
    a_ovf_sets: assert property (p_ovf_sets)
        else $error("overflow did not set flag zero");

    property p_reload_keep_high;
        @(posedge sys_clk) disable iff (rst)
        (mode_zero == MODE_8RELD && !wr_t0h) |=>
            $stable(timer_zero_high_byte);
    endproperty
    a_reload_keep_high: assert property (p_reload_keep_high)
        else $error("reload mode changed high byte");

    property p_m0_upper;
        @(posedge sys_clk) disable iff (rst)
        (mode_zero == MODE_13BIT && !wr_t0l) |=>
            timer_zero_low_byte[7:5] == $past(timer_zero_low_byte[7:5]);
    endproperty
    a_m0_upper: assert property (p_m0_upper)
        else $error("mode zero upper low bits changed");

    property p_split_stop;
        @(posedge sys_clk) disable iff (rst)
        (mode_one == MODE_SPLIT && !wr_t1l && !wr_t1h) |=>
            $stable(timer_one_low_byte);
    endproperty
    a_split_stop: assert property (p_split_stop)
        else $error("timer one moved in mode three");

    property p_gate_low;
        @(posedge sys_clk) disable iff (rst)
        (t2_insel == INSEL_GATED && !count_gate_pin_two
         && !t2_reload_now && !wr_t2l && !wr_t2h) |=>
            $stable(timer_two_low_byte);
    endproperty
    a_gate_low: assert property (p_gate_low)
        else $error("timer two counted with gate low");

    sequence s_wrap2;
        (t2_reload == RELOAD_OVF) && step_two && t2_inc[16]
        && !wr_t2l && !wr_t2h;
    endsequence
    property p_reload_ovf;
        @(posedge sys_clk) disable iff (rst)
        s_wrap2 |=> timer_two_low_byte == $past(reload_low)
                    && timer_two_high_byte == $past(reload_high);
    endproperty
    a_reload_ovf: assert property (p_reload_ovf)
        else $error("timer two did not reload on overflow");

    property p_t2_step;
        @(posedge sys_clk) disable iff (rst)
        (step_two && !t2_reload_now && !wr_t2l && !wr_t2h) |=>
            timer_two_low_byte == $past(timer_two_low_byte) + 8'h01;
    endproperty
    a_t2_step: assert property (p_t2_step)
        else $error("timer two step did not advance low byte");

    property p_tick_spacing;
        @(posedge sys_clk) disable iff (rst)
        tick_twelve |=> !tick_twelve [*8] ##1 !tick_twelve;
    endproperty
    a_tick_spacing: assert property (p_tick_spacing)
        else $error("twelve-cycle tick too close");
endmodule : mtc_timers

//--- mtc_pin_model.sv
module mtc_pin_model (
    input  wire logic sys_clk,
    input  wire logic en,
    output logic      pin
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] phase;
    // two cycles per level, idle high as on a pulled-up pin
    always_ff @(posedge sys_clk) begin
        phase <= en ? phase + 2'h1 : 2'h0;
    end
    assign pin = ~phase[1];
endmodule : mtc_pin_model

//--- testbench.sv
module testbench;
    import mtc_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic        sys_clk, rst, wr, pin0, pin1, pin2, of0;
    logic [7:0]  addr, wdata, rdata, hi;
    logic [15:0] v;
    logic [2:0]  en;
    logic [3:0]  svc;
    int          r, miscompares, checks;
    mtc_timers DUT (
        .sys_clk(sys_clk), .rst(rst), .sfr_addr(addr), .sfr_wr(wr),
        .sfr_wdata(wdata), .sfr_rdata(rdata), .count_pin_zero(pin0),
        .count_pin_one(pin1), .count_gate_pin_two(pin2),
        .reload_trigger_input(1'b1), .ext_irq_pin_zero_n(1'b1),
        .ext_irq_pin_one_n(1'b1), .service_ovf_zero(svc[0]),
        .service_ovf_one(svc[1]), .service_irq_zero(svc[2]),
        .service_irq_one(svc[3]), .overflow_flag_zero(of0),
        .overflow_flag_one(), .ext_irq_flag_zero(), .ext_irq_flag_one(),
        .timer_one_overflow_pulse()
    );
    mtc_pin_model src0 (.sys_clk(sys_clk), .en(en[0]), .pin(pin0));
    mtc_pin_model src1 (.sys_clk(sys_clk), .en(en[1]), .pin(pin1));
    mtc_pin_model src2 (.sys_clk(sys_clk), .en(en[2]), .pin(pin2));
    // ==========================================================
    // expectation and bus helpers
    function automatic logic [15:0] bump(logic [1:0] m, logic [15:0] x,
                                         int k);
        logic [12:0] c;
        repeat (k) begin
            c = {x[15:8], x[4:0]} + 13'h1;
            case (m)
                MODE_13BIT: x = {c[12:5], x[7:5], c[4:0]};
                MODE_8RELD: x = (x[7:0] == 8'hFF) ? {x[15:8], x[15:8]}
                                                   : x + 16'h1;
                default: x = x + 16'h1;
            endcase
        end
        return x;
    endfunction : bump
    task automatic wreg(input logic [7:0] a, d);
        @(negedge sys_clk);
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(negedge sys_clk);
        wr = 1'b0;
    endtask : wreg
    // read data lags the address by one cycle; t allows prescaler phase
    task automatic chk(input logic [7:0] a, e, t);
        logic [7:0] d;
        @(negedge sys_clk);
        addr = a;
        @(negedge sys_clk);
        d = rdata - e;
        checks++;
        if ((d > t) !== 1'b0) begin
            miscompares++;
            $display("wrong value reg%h exp %h got %h", a, e, rdata);
        end
    endtask : chk
    task automatic edges(input int w, input int k);
        @(negedge sys_clk);
        en[w] = 1'b1;
        repeat (4 * k) @(negedge sys_clk);
        en[w] = 1'b0;
        repeat (4) @(negedge sys_clk);
    endtask : edges
    task automatic final_report;
        if (miscompares == 0 && checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : final_report
    // ==========================================================
    // clock, watchdog and main sequence
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    initial begin
        repeat (20000) @(posedge sys_clk);
        miscompares++;
        final_report();
    end
    initial begin
        {rst, wr, en, svc, addr, wdata} = {1'b1, 1'b0, 3'h0, 4'h0, 16'h0};
        miscompares = 0;
        checks = 0;
        void'($urandom(32'h9F92));
        repeat (3) @(negedge sys_clk);
        rst = 1'b0;
        chk(ADDR_RUN_FLAG, RESET_BYTE, 8'h00);
        chk(8'h00, 8'h00, 8'h00);
        for (int m = 0; m < 3; m++) begin
            r = $urandom_range(3);
            hi = (m == 2) ? 8'($urandom) : 8'hFF;
            wreg(ADDR_MODE_SEL, 8'h04 | 8'(m));
            wreg(ADDR_T0_HIGH, hi);
            wreg(ADDR_T0_LOW, 8'(255 - r));
            wreg(ADDR_RUN_FLAG, 8'h10);
            edges(0, r + 1);
            v = bump(2'(m), {hi, 8'(255 - r)}, r + 1);
            chk(ADDR_T0_LOW, v[7:0], 8'h00);
            chk(ADDR_T0_HIGH, v[15:8], 8'h00);
            chk(ADDR_RUN_FLAG, 8'h30, 8'h00);
            checks++;
            if (of0 !== 1'b1) begin
                miscompares++;
                $display("wrong value overflow_flag_zero exp 1 got %b", of0);
            end
            svc = 4'hF;
            @(negedge sys_clk);
            svc = 4'h0;
            chk(ADDR_RUN_FLAG, 8'h10, 8'h00);
        end
        wreg(ADDR_T1_LOW, 8'h00);
        wreg(ADDR_MODE_SEL, 8'h70);
        wreg(ADDR_RUN_FLAG, 8'h40);
        edges(1, 3);
        chk(ADDR_T1_LOW, 8'h00, 8'h00);
        wreg(ADDR_MODE_SEL, 8'h50);
        wreg(ADDR_RUN_FLAG, 8'h00);
        edges(1, 3);
        chk(ADDR_T1_LOW, 8'h00, 8'h00);
        wreg(ADDR_RUN_FLAG, 8'h40);
        edges(1, 3);
        chk(ADDR_T1_LOW, 8'h03, 8'h00);
        wreg(ADDR_MODE_SEL, 8'h01);
        wreg(ADDR_T0_LOW, 8'h00);
        wreg(ADDR_RUN_FLAG, 8'h10);
        repeat (240) @(negedge sys_clk);
        chk(ADDR_T0_LOW, 8'h13, 8'h02);
        for (int p = 0; p < 2; p++) begin
            wreg(ADDR_T2_CTRL, 8'(p * 128 + 1));
            wreg(ADDR_T2_LOW, 8'h00);
            repeat (240) @(negedge sys_clk);
            chk(ADDR_T2_LOW, 8'(19 / (p + 1)), 8'h02);
        end
        r = $urandom_range(3);
        hi = 8'($urandom_range(126));
        wreg(ADDR_T2_CTRL, 8'h12);
        wreg(ADDR_RELOAD_LOW, hi);
        wreg(ADDR_RELOAD_HI, 8'hA5);
        wreg(ADDR_T2_HIGH, 8'hFF);
        wreg(ADDR_T2_LOW, 8'(255 - r));
        edges(2, r + 2);
        chk(ADDR_T2_LOW, hi + 8'h01, 8'h00);
        chk(ADDR_T2_HIGH, 8'hA5, 8'h00);
        final_report();
    end
endmodule : testbench
